/* File: design/flp_pkg.sv */
// Package with offsets, fields, codes and timing for the lock-bit controller
`default_nettype none
package flp_pkg;
  // Clock
  localparam int CLK_NS = 8;
  // Bus cycle and busy settle timing on the flash pins, in ns, then in cycles (rounded up)
  localparam int ADDR_SETUP_NS = 40;
  localparam int STROBE_NS = 64;
  localparam int HOLD_NS = 16;
  localparam int BUSY_SETTLE_NS = 100;
  localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ADDR = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  // Control fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LO = 1;
  localparam int CTRL_HV = 8;
  localparam int CTRL_VPP = 9;
  localparam int CTRL_CCODE_LO = 16;
  // Status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_BYTE_LO = 8;
  localparam int STAT_FAIL = 16;
  localparam int STAT_SEQ_ERR = 17;
  localparam int STAT_REPEAT = 18;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0] CCODE_RESET = 8'h00;
  // Command codes on the data pins
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h01;
  localparam logic [7:0] CMD_MASTER_CONFIRM = 8'hF1;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  // Device status byte bit positions
  localparam int SR_READY = 7;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_SUPPLY_ERR = 3;
  localparam int SR_PROTECT_ERR = 1;
  // Operations
  typedef enum logic [1:0] {
    OP_SET_BLOCK,
    OP_SET_MASTER,
    OP_CLEAR_LOCKS,
    OP_CLEAR_STATUS
  } flp_op_t;
endpackage
`default_nettype wire

/* File: design/flp_bus_cycle.sv */
// One asynchronous write or read cycle on the flash pins
`timescale 1ns/10ps
`default_nettype none
module flp_bus_cycle #(
  parameter int ADDR_W = 21
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request
  input wire logic start,
  input wire logic rd,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] data_in,
  output logic done_r,
  output logic [7:0] rdata_r,
  // Flash pins
  output logic [ADDR_W-1:0] addr_r,
  output logic [7:0] dq_out_r,
  input wire logic [7:0] dq_in,
  output logic dq_oe_r,
  output logic ce_n_r,
  output logic we_n_r,
  output logic oe_n_r
);
  typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} flp_eng_t;
  flp_eng_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [ADDR_W-1:0] addr_nxt;
  logic [7:0] dq_out_nxt, rdata_nxt;
  logic dq_oe_nxt, ce_n_nxt, we_n_nxt, oe_n_nxt, done_nxt, rd_r, rd_nxt;

  // Cycle phases: address setup, strobe low, hold
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    dq_out_nxt = dq_out_r;
    rdata_nxt = rdata_r;
    dq_oe_nxt = dq_oe_r;
    ce_n_nxt = ce_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    rd_nxt = rd_r;
    done_nxt = 1'b0;
    unique case (st_r)
      E_IDLE: begin
        if (start) begin
          addr_nxt = addr_in;
          dq_out_nxt = data_in;
          dq_oe_nxt = !rd;
          rd_nxt = rd;
          ce_n_nxt = 1'b0;
          cnt_nxt = 8'(flp_pkg::ADDR_SETUP_CYC - 1);
          st_nxt = E_SETUP;
        end
      end
      E_SETUP: begin
        if (cnt_r == 8'h00) begin
          we_n_nxt = rd_r;
          oe_n_nxt = !rd_r;
          cnt_nxt = 8'(flp_pkg::STROBE_CYC - 1);
          st_nxt = E_STROBE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      E_STROBE: begin
        if (cnt_r == 8'h00) begin
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          if (rd_r) begin
            rdata_nxt = dq_in;
          end
          cnt_nxt = 8'(flp_pkg::HOLD_CYC - 1);
          st_nxt = E_HOLD;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      E_HOLD: begin
        if (cnt_r == 8'h00) begin
          ce_n_nxt = 1'b1;
          dq_oe_nxt = 1'b0;
          done_nxt = 1'b1;
          st_nxt = E_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= E_IDLE;
      cnt_r <= 8'h00;
      addr_r <= '0;
      dq_out_r <= 8'h00;
      rdata_r <= 8'h00;
      dq_oe_r <= 1'b0;
      ce_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      rd_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      dq_out_r <= dq_out_nxt;
      rdata_r <= rdata_nxt;
      dq_oe_r <= dq_oe_nxt;
      ce_n_r <= ce_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
    end
  end
endmodule // flp_bus_cycle
`default_nettype wire

/* File: design/flp_ctrl.sv */
// Host controller running lock-bit commands on the flash over AHB-Lite
`timescale 1ns/10ps
`default_nettype none
module flp_ctrl #(
  parameter int ADDR_W = 21
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  input wire logic [7:0] flash_dq_in,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  input wire logic ready_busy_output,
  output logic reset_pin_hv_sel,
  output logic program_supply_en
);
  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_CONFIRM, S_SETTLE, S_WAIT_RDY,
    S_STAT_RD, S_CLR_WR} flp_state_t;
  flp_state_t st_r, st_nxt;
  flp_pkg::flp_op_t op_r, op_nxt;
  logic [ADDR_W-1:0] taddr_r, taddr_nxt;
  logic [7:0] ccode_r, ccode_nxt, sbyte_r, sbyte_nxt, cnt_r, cnt_nxt, ewdata;
  logic hv_r, hv_nxt, vpp_r, vpp_nxt, done_r, done_nxt, fail_r, fail_nxt;
  logic seq_r, seq_nxt, rep_r, rep_nxt, go, estart_r, estart_nxt, erd;
  logic dph_wr_r, dph_wr_nxt, eng_done, stat_err;
  logic [3:0] dph_ofs_r, dph_ofs_nxt;
  logic [31:0] hrdata_nxt;
  logic [7:0] eng_rdata;

  // AHB data phase capture; always zero wait, always OKAY
  always_comb begin
    dph_wr_nxt = hsel && htrans[1] && hready && hwrite;
    dph_ofs_nxt = haddr[3:0];
    hrdata_nxt = hrdata;
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[3:0])
        flp_pkg::OFS_CTRL: hrdata_nxt = {8'h00, ccode_r, 6'h00, vpp_r, hv_r, 5'h00,
          op_r, 1'b0};
        flp_pkg::OFS_ADDR: hrdata_nxt = 32'(taddr_r);
        flp_pkg::OFS_STATUS: hrdata_nxt = {13'h0, rep_r, seq_r, fail_r, sbyte_r,
          6'h00, done_r, st_r != S_IDLE};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_r <= 1'b0;
      dph_ofs_r <= 4'h0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dph_wr_r <= dph_wr_nxt;
      dph_ofs_r <= dph_ofs_nxt;
      hrdata <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Any of the error flags in the returned status byte
  assign stat_err = eng_rdata[flp_pkg::SR_ERASE_ERR] || eng_rdata[flp_pkg::SR_PROG_ERR] ||
    eng_rdata[flp_pkg::SR_SUPPLY_ERR] || eng_rdata[flp_pkg::SR_PROTECT_ERR];
  assign go = dph_wr_r && dph_ofs_r == flp_pkg::OFS_CTRL && hwdata[flp_pkg::CTRL_GO] &&
    st_r == S_IDLE;

  // Command sequencer
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    taddr_nxt = taddr_r;
    ccode_nxt = ccode_r;
    hv_nxt = hv_r;
    vpp_nxt = vpp_r;
    sbyte_nxt = sbyte_r;
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    fail_nxt = fail_r;
    seq_nxt = seq_r;
    rep_nxt = rep_r;
    estart_nxt = 1'b0;
    erd = 1'b0;
    ewdata = flp_pkg::CMD_LOCK_SETUP;
    // Pin level and settings only change while idle
    if (dph_wr_r && st_r == S_IDLE) begin
      if (dph_ofs_r == flp_pkg::OFS_CTRL) begin
        op_nxt = flp_pkg::flp_op_t'(hwdata[flp_pkg::CTRL_OP_LO +: 2]);
        hv_nxt = hwdata[flp_pkg::CTRL_HV];
        vpp_nxt = hwdata[flp_pkg::CTRL_VPP];
        ccode_nxt = hwdata[flp_pkg::CTRL_CCODE_LO +: 8];
      end else if (dph_ofs_r == flp_pkg::OFS_ADDR) begin
        taddr_nxt = hwdata[ADDR_W-1:0];
      end
    end
    unique case (st_r)
      S_IDLE: begin
        if (go) begin
          done_nxt = 1'b0;
          fail_nxt = 1'b0;
          seq_nxt = 1'b0;
          rep_nxt = 1'b0;
          estart_nxt = 1'b1;
          if (hwdata[flp_pkg::CTRL_OP_LO +: 2] == 2'(flp_pkg::OP_CLEAR_STATUS)) begin
            st_nxt = S_CLR_WR;
          end else begin
            st_nxt = S_SETUP;
          end
        end
      end
      S_SETUP: begin
        ewdata = flp_pkg::CMD_LOCK_SETUP;
        if (eng_done) begin
          estart_nxt = 1'b1;
          st_nxt = S_CONFIRM;
        end
      end
      S_CONFIRM: begin
        unique case (op_r)
          flp_pkg::OP_SET_BLOCK: ewdata = flp_pkg::CMD_BLOCK_CONFIRM;
          flp_pkg::OP_SET_MASTER: ewdata = flp_pkg::CMD_MASTER_CONFIRM;
          default: ewdata = ccode_r;
        endcase
        if (eng_done) begin
          cnt_nxt = 8'(flp_pkg::BUSY_SETTLE_CYC);
          st_nxt = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (cnt_r == 8'h00) begin
          st_nxt = S_WAIT_RDY;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      S_WAIT_RDY: begin
        if (ready_busy_output) begin
          estart_nxt = 1'b1;
          st_nxt = S_STAT_RD;
        end
      end
      S_STAT_RD: begin
        erd = 1'b1;
        if (eng_done) begin
          sbyte_nxt = eng_rdata;
          seq_nxt = eng_rdata[flp_pkg::SR_ERASE_ERR] && eng_rdata[flp_pkg::SR_PROG_ERR];
          fail_nxt = stat_err;
          rep_nxt = op_r == flp_pkg::OP_CLEAR_LOCKS &&
            eng_rdata[flp_pkg::SR_ERASE_ERR];
          if (stat_err) begin
            estart_nxt = 1'b1;
            st_nxt = S_CLR_WR;
          end else begin
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
          end
        end
      end
      S_CLR_WR: begin
        ewdata = flp_pkg::CMD_CLEAR_STATUS;
        if (eng_done) begin
          done_nxt = 1'b1;
          st_nxt = S_IDLE;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= S_IDLE;
      op_r <= flp_pkg::OP_SET_BLOCK;
      taddr_r <= '0;
      ccode_r <= flp_pkg::CCODE_RESET;
      hv_r <= 1'b0;
      vpp_r <= 1'b0;
      sbyte_r <= 8'h00;
      cnt_r <= 8'h00;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      seq_r <= 1'b0;
      rep_r <= 1'b0;
      estart_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      taddr_r <= taddr_nxt;
      ccode_r <= ccode_nxt;
      hv_r <= hv_nxt;
      vpp_r <= vpp_nxt;
      sbyte_r <= sbyte_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
      seq_r <= seq_nxt;
      rep_r <= rep_nxt;
      estart_r <= estart_nxt;
    end
  end

  assign reset_pin_hv_sel = hv_r;
  assign program_supply_en = vpp_r;

  flp_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(estart_r),
    .rd(erd),
    .addr_in(taddr_r),
    .data_in(ewdata),
    .done_r(eng_done),
    .rdata_r(eng_rdata),
    .addr_r(flash_addr),
    .dq_out_r(flash_dq_out),
    .dq_in(flash_dq_in),
    .dq_oe_r(flash_dq_oe),
    .ce_n_r(flash_ce_n),
    .we_n_r(flash_we_n),
    .oe_n_r(flash_oe_n)
  );

  // Checks
  property p_confirm_after_setup;
    @(posedge hclk) disable iff (!hresetn) st_r == S_SETUP && eng_done |=> st_r == S_CONFIRM;
  endproperty
  a_confirm_after_setup: assert property (p_confirm_after_setup)
    else $error("setup write not followed by confirm");
  property p_confirm_addr;
    @(posedge hclk) disable iff (!hresetn)
      st_r == S_CONFIRM && !flash_we_n |-> flash_addr == taddr_r;
  endproperty
  a_confirm_addr: assert property (p_confirm_addr)
    else $error("confirm write at wrong address");
  property p_setup_code;
    @(posedge hclk) disable iff (!hresetn)
      st_r == S_SETUP && !flash_we_n |-> flash_dq_out == 8'h60 && flash_dq_oe;
  endproperty
  a_setup_code: assert property (p_setup_code)
    else $error("setup code not 60H");
  property p_block_confirm_code;
    @(posedge hclk) disable iff (!hresetn)
      st_r == S_CONFIRM && !flash_we_n && op_r == flp_pkg::OP_SET_BLOCK
      |-> flash_dq_out == 8'h01;
  endproperty
  a_block_confirm_code: assert property (p_block_confirm_code)
    else $error("block confirm code not 01H");
  property p_err_then_clear;
    @(posedge hclk) disable iff (!hresetn)
      st_r == S_STAT_RD && eng_done && stat_err |=> st_r == S_CLR_WR ##[1:40] !flash_we_n;
  endproperty
  a_err_then_clear: assert property (p_err_then_clear)
    else $error("error seen but no clear status issued");
  property p_clear_code;
    @(posedge hclk) disable iff (!hresetn)
      st_r == S_CLR_WR && !flash_we_n |-> flash_dq_out == 8'h50;
  endproperty
  a_clear_code: assert property (p_clear_code)
    else $error("clear status code not 50H");
  property p_hv_stable;
    @(posedge hclk) disable iff (!hresetn)
      st_r != S_IDLE && $past(st_r) != S_IDLE |-> $stable(reset_pin_hv_sel);
  endproperty
  a_hv_stable: assert property (p_hv_stable)
    else $error("reset pin level changed during operation");
  property p_repeat_flag;
    @(posedge hclk) disable iff (!hresetn)
      st_r == S_STAT_RD && eng_done && op_r == flp_pkg::OP_CLEAR_LOCKS &&
      eng_rdata[flp_pkg::SR_ERASE_ERR] |=> rep_r [*2];
  endproperty
  a_repeat_flag: assert property (p_repeat_flag)
    else $error("failed clear not flagged for repeat");
  c_set_block_ok: cover property (@(posedge hclk) st_r == S_STAT_RD && eng_done &&
    !stat_err && op_r == flp_pkg::OP_SET_BLOCK);
  c_master_fail: cover property (@(posedge hclk) st_r == S_STAT_RD && eng_done &&
    stat_err && op_r == flp_pkg::OP_SET_MASTER);
  c_clear_err: cover property (@(posedge hclk) st_r == S_CLR_WR && eng_done);
endmodule // flp_ctrl
`default_nettype wire

/* File: tb/flp_flash_model.sv */
// Behavioural flash device holding block and master lock bits
`timescale 1ns/10ps
`default_nettype none
module flp_flash_model #(
  parameter int ADDR_W = 21,
  parameter int BUSY_NS = 400,
  parameter logic [7:0] CLEAR_CODE = 8'hA7
) (
  // Flash bus
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  output logic [7:0] flash_dq_in,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  // Status and levels
  output logic ready_busy_output,
  input wire logic reset_pin_hv_sel,
  input wire logic program_supply_en
);
  logic master_r = 1'b0;
  logic [31:0] lock_r = 32'h0;
  logic [7:0] sr_r = 8'h80;
  logic setup_r = 1'b0;
  initial ready_busy_output = 1'b1;
  initial flash_dq_in = 8'h00;

  // Status byte when read, changing pattern when released
  always @(flash_ce_n, flash_oe_n, sr_r) begin
    if (!flash_ce_n && !flash_oe_n)
      flash_dq_in = sr_r;
    else
      flash_dq_in = ~flash_dq_in;
  end

  task automatic run_op(input logic [7:0] c, input logic [4:0] b);
    ready_busy_output = 1'b0;
    sr_r[7] = 1'b0;
    #(BUSY_NS);
    if (c == flp_pkg::CMD_BLOCK_CONFIRM || c == flp_pkg::CMD_MASTER_CONFIRM) begin
      if (!program_supply_en)
        sr_r |= 8'h18;
      else if (!reset_pin_hv_sel && (master_r || c != flp_pkg::CMD_BLOCK_CONFIRM))
        sr_r |= 8'h12;
      else if (c == flp_pkg::CMD_BLOCK_CONFIRM)
        lock_r[b] = 1'b1;
      else
        master_r = 1'b1;
    end else if (c == CLEAR_CODE) begin
      if (!program_supply_en)
        sr_r |= 8'h28;
      else if (master_r && !reset_pin_hv_sel)
        sr_r |= 8'h22;
      else
        lock_r = 32'h0;
    end else
      sr_r |= 8'h30;
    sr_r[7] = 1'b1;
    ready_busy_output = 1'b1;
  endtask

  // Command latch on the rising write strobe
  always @(posedge flash_we_n) begin
    if (!flash_ce_n && flash_dq_oe) begin
      if (setup_r) begin
        setup_r = 1'b0;
        run_op(flash_dq_out, flash_addr[ADDR_W-1 -: 5]);
      end else if (flash_dq_out == flp_pkg::CMD_LOCK_SETUP)
        setup_r = 1'b1;
      else if (flash_dq_out == flp_pkg::CMD_CLEAR_STATUS)
        sr_r &= 8'hC5;
    end
  end
endmodule // flp_flash_model
`default_nettype wire

/* File: tb/flp_ctrl_bench.sv */
// Testbench for the lock-bit controller against a flash model
`timescale 1ns/10ps
`default_nettype none
module flp_ctrl_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [20:0] f_addr;
  logic [7:0] f_dout;
  logic [7:0] f_din;
  logic f_oe, f_ce_n, f_we_n, f_oe_n, f_rb, f_hv, f_sup;
  logic rd_ph = 1'b0;
  logic [31:0] rd_last;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] lfsr_r = 32'hC0EB;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  always #4 hclk = ~hclk;

  flp_ctrl #(.ADDR_W(21)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash_addr(f_addr), .flash_dq_out(f_dout),
    .flash_dq_in(f_din), .flash_dq_oe(f_oe), .flash_ce_n(f_ce_n), .flash_we_n(f_we_n),
    .flash_oe_n(f_oe_n), .ready_busy_output(f_rb), .reset_pin_hv_sel(f_hv),
    .program_supply_en(f_sup)
  );

  flp_flash_model #(.ADDR_W(21), .BUSY_NS(404), .CLEAR_CODE(8'hA7)) flash_u (
    .flash_addr(f_addr), .flash_dq_out(f_dout), .flash_dq_in(f_din), .flash_dq_oe(f_oe),
    .flash_ce_n(f_ce_n), .flash_we_n(f_we_n), .flash_oe_n(f_oe_n),
    .ready_busy_output(f_rb), .reset_pin_hv_sel(f_hv), .program_supply_en(f_sup)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic fail(input string s);
    err_count++;
    $display("unexpected at %0t: %s", $time, s);
  endtask

  task automatic chk(input logic c, input string s);
    checked++;
    if (c !== 1'b1)
      fail(s);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Read results against the oldest expectation
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      if (exp_q.size() == 0)
        fail("read with no expectation");
      else begin
        if (msk_q[0] != 32'h0) begin
          checked++;
          if ((hrdata & msk_q[0]) !== (exp_q[0] & msk_q[0]) || hresp !== 1'b0)
            fail($sformatf("read %h expected %h", hrdata, exp_q[0]));
        end
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
    rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail("timeout");
      results();
    end
  end

  task automatic bus(input logic wr, input logic [3:0] ofs, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {28'h0, ofs};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_last = hrdata;
  endtask

  task automatic rd(input logic [3:0] ofs, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, ofs, 32'h0);
  endtask

  // One operation: start, refused rewrite, poll, final status
  task automatic run(input logic [1:0] op, input logic hv, input logic sup,
                     input logic [7:0] code, input logic [7:0] sb, input logic [31:0] m);
    logic [31:0] ctl;
    logic [31:0] a;
    int n = 0;
    lfsr_r = lfsr_next(lfsr_r);
    a = {11'h0, lfsr_r[20:0]};
    ctl = {8'h0, code, 6'h0, sup, hv, 5'h0, op, 1'b1};
    bus(1'b1, flp_pkg::OFS_ADDR, a);
    rd(flp_pkg::OFS_ADDR, a, 32'h001F_FFFF);
    bus(1'b1, flp_pkg::OFS_CTRL, ctl);
    rd(flp_pkg::OFS_STATUS, 32'h1, 32'h1);
    bus(1'b1, flp_pkg::OFS_CTRL, ctl ^ 32'h6);
    do begin
      rd(flp_pkg::OFS_STATUS, 32'h0, 32'h0);
      n++;
    end while (rd_last[0] !== 1'b0 && n < 400);
    rd(flp_pkg::OFS_CTRL, ctl & 32'hFFFF_FFFE, 32'h00FF_0307);
    rd(flp_pkg::OFS_STATUS, {13'h0, op == 2'h2 && sb[5], sb[5] && sb[4], |(sb & 8'h3A), sb,
       8'h2}, m);
    $display("test op %0d hv %0d supply %0d ended at %0t", op, hv, sup, $time);
  endtask

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(flp_pkg::OFS_CTRL, flp_pkg::CTRL_RESET, 32'hFFFF_FFFF);
    rd(4'hC, 32'h0, 32'hFFFF_FFFF);
    rd(flp_pkg::OFS_STATUS, 32'h0, 32'h0007_FFFF);
    run(2'h0, 1'b0, 1'b1, 8'h00, 8'h80, 32'h0007_FFFF);
    run(2'h1, 1'b0, 1'b1, 8'h00, 8'h92, 32'h0007_FFFF);
    run(2'h1, 1'b1, 1'b0, 8'h00, 8'h98, 32'h0007_FFFF);
    chk(flash_u.master_r === 1'b0, "master bit changed");
    run(2'h1, 1'b1, 1'b1, 8'h00, 8'h80, 32'h0007_FFFF);
    run(2'h0, 1'b0, 1'b1, 8'h00, 8'h92, 32'h0007_FFFF);
    run(2'h0, 1'b1, 1'b1, 8'h00, 8'h80, 32'h0007_FFFF);
    run(2'h2, 1'b0, 1'b1, 8'hA7, 8'hA2, 32'h0007_FFFF);
    run(2'h2, 1'b1, 1'b0, 8'hA7, 8'hA8, 32'h0007_FFFF);
    chk(flash_u.lock_r !== 32'h0, "locks cleared at low supply");
    run(2'h2, 1'b1, 1'b1, 8'h3C, 8'hB0, 32'h0007_FFFF);
    run(2'h2, 1'b1, 1'b1, 8'hA7, 8'h80, 32'h0007_FFFF);
    run(2'h3, 1'b0, 1'b1, 8'h00, 8'h00, 32'h0000_0003);
    chk(flash_u.master_r === 1'b1 && flash_u.lock_r === 32'h0, "lock state");
    results();
  end
endmodule // flp_ctrl_bench
`default_nettype wire
